// [swsc_top.sv]
// Sampling wave, write window and shift register control of the sampler
`timescale 1ns/1ns
module swsc_top (
  // System clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Wave control pins
  input wire logic wave_run_enable,
  input wire logic sample_write_gate,
  input wire logic wave_continuous_select,
  input wire logic ref_clock_in,
  // Shift register link
  input wire logic shift_clock_in,
  input wire logic shift_serial_in,
  input wire logic chain_shift_in,
  input wire logic read_shift_load,
  // Shift register outputs
  output logic chain_shift_out,
  output logic muxed_shift_out,
  // Wave status
  output logic wave_tap_out,
  output logic lock_indicator,
  output swsc_pkg::swsc_window_type write_window
);

  // ----------------------------------------------------------------
  // Internal reset
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {WAVE_IDLE, WAVE_RUN, WAVE_DONE} swsc_wave_state_type;

  logic [3:0] reset_cnt_reg;
  logic core_rst_n_reg;
  logic core_rst_pre_reg;

  // Open reset pin reads high; core reset still held for the minimum width
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_cnt_reg <= swsc_pkg::RESET_CNT_ZERO;
      core_rst_pre_reg <= 1'b0;
    end else if (reset_cnt_reg < 4'(swsc_pkg::RESET_CYCLES)) begin
      reset_cnt_reg <= reset_cnt_reg + 4'h1;
    end else begin
      core_rst_pre_reg <= 1'b1;
    end
  end

  // Second stage keeps the released reset glitch free
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_rst_n_reg <= 1'b0;
    end else begin
      core_rst_n_reg <= core_rst_pre_reg;
    end
  end

  // ----------------------------------------------------------------
  // Control pin synchronisation
  // ----------------------------------------------------------------
  swsc_pkg::swsc_ctrl_type ctrl;
  logic [swsc_pkg::CTRL_PINS-1:0] ctrl_levels;

  swsc_pin_sync #(
    .WIDTH(swsc_pkg::CTRL_PINS)
  ) u_ctrl_sync (
    .clk(clk),
    .reset_n(core_rst_n_reg),
    .pins_in({ref_clock_in, wave_continuous_select, sample_write_gate, wave_run_enable}),
    .levels_out(ctrl_levels)
  );

  assign ctrl = ctrl_levels;

  // ----------------------------------------------------------------
  // Sampling wave
  // ----------------------------------------------------------------
  swsc_wave_state_type wave_state_reg;
  logic [swsc_pkg::CELL_W-1:0] cell_reg;
  logic enable_prev_reg;
  logic enable_rise;

  assign enable_rise = ctrl.run_enable && !enable_prev_reg;

  // Edge detector on the filtered enable level
  always_ff @(posedge clk or negedge core_rst_n_reg) begin
    if (!core_rst_n_reg) begin
      enable_prev_reg <= 1'b0;
    end else begin
      enable_prev_reg <= ctrl.run_enable;
    end
  end

  // Wave sequence: launch, circulate or single pass, halt
  always_ff @(posedge clk or negedge core_rst_n_reg) begin
    if (!core_rst_n_reg) begin
      wave_state_reg <= WAVE_IDLE;
      cell_reg <= swsc_pkg::CELL_FIRST;
    end else if (!ctrl.run_enable) begin
      wave_state_reg <= WAVE_IDLE;
    end else begin
      unique case (wave_state_reg)
        WAVE_IDLE: begin
          if (enable_rise) begin
            wave_state_reg <= WAVE_RUN;
            cell_reg <= swsc_pkg::CELL_FIRST;
          end
        end
        WAVE_RUN: begin
          if (cell_reg == swsc_pkg::CELL_LAST) begin
            if (ctrl.continuous) begin
              cell_reg <= swsc_pkg::CELL_FIRST;
            end else begin
              wave_state_reg <= WAVE_DONE;
            end
          end else begin
            cell_reg <= cell_reg + 10'h001;
          end
        end
        WAVE_DONE: begin
          wave_state_reg <= WAVE_DONE;
        end
        // Fourth code of the state word is unused; recover to idle
        default: begin
          wave_state_reg <= WAVE_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wave tap
  // ----------------------------------------------------------------
  logic tap_reg;
  logic tap_hit;

  assign tap_hit = (wave_state_reg == WAVE_RUN) && (cell_reg == swsc_pkg::CELL_TAP);

  // Toggles on each pass of the tap cell, once per revolution
  always_ff @(posedge clk or negedge core_rst_n_reg) begin
    if (!core_rst_n_reg) begin
      tap_reg <= 1'b0;
    end else if (tap_hit) begin
      tap_reg <= !tap_reg;
    end
  end

  assign wave_tap_out = tap_reg;

  // ----------------------------------------------------------------
  // Write window and stop cell
  // ----------------------------------------------------------------
  logic writing;
  logic [swsc_pkg::CELL_W-1:0] stop_cell_reg;
  logic frozen_reg;

  assign writing = (wave_state_reg == WAVE_RUN) && ctrl.write_gate;

  // Window head follows the wave, tail trails by a fixed span
  always_ff @(posedge clk or negedge core_rst_n_reg) begin
    if (!core_rst_n_reg) begin
      write_window <= '0;
    end else begin
      write_window.active <= writing;
      write_window.running <= (wave_state_reg == WAVE_RUN);
      write_window.head <= cell_reg;
      write_window.tail <= cell_reg - swsc_pkg::WINDOW_SPAN;
    end
  end

  // Last written cell is frozen while writing is off
  always_ff @(posedge clk or negedge core_rst_n_reg) begin
    if (!core_rst_n_reg) begin
      stop_cell_reg <= swsc_pkg::CELL_FIRST;
      frozen_reg <= 1'b1;
    end else if (writing) begin
      stop_cell_reg <= cell_reg;
      frozen_reg <= 1'b0;
    end else begin
      frozen_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Lock indicator
  // ----------------------------------------------------------------
  logic [swsc_pkg::LOCK_W-1:0] lock_cnt_reg;
  logic lock_reg;
  logic phase_err;

  assign phase_err = tap_reg ^ ctrl.ref_level;

  // Integrates the tap versus reference difference like the filter cap
  always_ff @(posedge clk or negedge core_rst_n_reg) begin
    if (!core_rst_n_reg) begin
      lock_cnt_reg <= swsc_pkg::LOCK_MAX;
    end else if (phase_err) begin
      if (lock_cnt_reg != swsc_pkg::LOCK_MAX) begin
        lock_cnt_reg <= lock_cnt_reg + swsc_pkg::LOCK_STEP;
      end
    end else if (lock_cnt_reg != swsc_pkg::LOCK_ZERO) begin
      lock_cnt_reg <= lock_cnt_reg - swsc_pkg::LOCK_STEP;
    end
  end

  // Threshold with hysteresis
  always_ff @(posedge clk or negedge core_rst_n_reg) begin
    if (!core_rst_n_reg) begin
      lock_reg <= 1'b0;
    end else if (lock_cnt_reg < swsc_pkg::LOCK_ON) begin
      lock_reg <= 1'b1;
    end else if (lock_cnt_reg > swsc_pkg::LOCK_OFF) begin
      lock_reg <= 1'b0;
    end
  end

  assign lock_indicator = lock_reg;

  // ----------------------------------------------------------------
  // Link domain reset
  // ----------------------------------------------------------------
  logic link_rst_pre_reg;
  logic link_rst_n_reg;

  // Released on shift clock edges once any arrive
  always_ff @(posedge shift_clock_in or negedge reset_n) begin
    if (!reset_n) begin
      link_rst_pre_reg <= 1'b0;
      link_rst_n_reg <= 1'b0;
    end else begin
      link_rst_pre_reg <= 1'b1;
      link_rst_n_reg <= link_rst_pre_reg;
    end
  end

  // ----------------------------------------------------------------
  // Link domain crossing
  // ----------------------------------------------------------------
  logic [1:0] link_levels;
  logic gate_link;
  logic frozen_link;

  swsc_pin_sync #(
    .WIDTH(2)
  ) u_link_sync (
    .clk(shift_clock_in),
    .reset_n(link_rst_n_reg),
    .pins_in({frozen_reg, sample_write_gate}),
    .levels_out(link_levels)
  );

  assign gate_link = link_levels[0];
  assign frozen_link = link_levels[1];

  logic frozen_prev_reg;
  logic [swsc_pkg::CELL_W-1:0] stop_cell_link_reg;

  // Stop cell copied once, as the frozen level settles on the link side
  // Writing must stay off a few shift clocks after it stops, or the copy may tear
  always_ff @(posedge shift_clock_in or negedge link_rst_n_reg) begin
    if (!link_rst_n_reg) begin
      frozen_prev_reg <= 1'b0;
      stop_cell_link_reg <= swsc_pkg::CELL_FIRST;
    end else begin
      frozen_prev_reg <= frozen_link;
      if (frozen_link && !frozen_prev_reg) begin
        stop_cell_link_reg <= stop_cell_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shift registers
  // ----------------------------------------------------------------
  logic [swsc_pkg::CELL_COUNT-1:0] read_sr_reg;
  logic [swsc_pkg::CELL_COUNT-1:0] read_sr_next;
  logic [swsc_pkg::WSR_BITS-1:0] write_sr_reg;
  logic [swsc_pkg::WSR_BITS-1:0] write_sr_next;
  logic [swsc_pkg::CELL_COUNT-1:0] load_pattern;

  // One-hot token at the captured stop cell
  always_comb begin
    load_pattern = '0;
    load_pattern[stop_cell_link_reg] = frozen_link;
  end

  // Next value of each register under the shared shift clock
  always_comb begin
    read_sr_next = read_sr_reg;
    write_sr_next = write_sr_reg;
    if (read_shift_load) begin
      read_sr_next = load_pattern;
    end else if (!gate_link) begin
      read_sr_next = {read_sr_reg[swsc_pkg::CELL_COUNT-2:0], shift_serial_in};
    end
    if (gate_link) begin
      write_sr_next = {write_sr_reg[swsc_pkg::WSR_BITS-2:0], chain_shift_in};
    end
  end

  // Register updates on the shift clock
  always_ff @(posedge shift_clock_in or negedge link_rst_n_reg) begin
    if (!link_rst_n_reg) begin
      read_sr_reg <= '0;
      write_sr_reg <= '0;
    end else begin
      read_sr_reg <= read_sr_next;
      write_sr_reg <= write_sr_next;
    end
  end

  // Output flops: chain and multiplexed serial outputs
  always_ff @(posedge shift_clock_in or negedge link_rst_n_reg) begin
    if (!link_rst_n_reg) begin
      chain_shift_out <= 1'b0;
      muxed_shift_out <= 1'b0;
    end else if (gate_link) begin
      chain_shift_out <= write_sr_next[swsc_pkg::WSR_BITS-1];
      muxed_shift_out <= write_sr_next[swsc_pkg::WSR_BITS-1];
    end else begin
      chain_shift_out <= read_sr_next[swsc_pkg::CELL_COUNT-1];
      muxed_shift_out <= read_sr_next[swsc_pkg::CELL_COUNT-1];
    end
  end

endmodule : swsc_top

// [swsc_pkg.sv]
// Shared constants and carrier types of the sampler wave and shift control
package swsc_pkg;

  // ----------------------------------------------------------------
  // Cell ring geometry
  // ----------------------------------------------------------------
  localparam int CELL_W = 10;
  localparam logic [CELL_W-1:0] CELL_FIRST = 10'h000;
  localparam logic [CELL_W-1:0] CELL_TAP = 10'h200;
  localparam logic [CELL_W-1:0] CELL_LAST = 10'h3FF;
  localparam int CELL_COUNT = 1024;
  localparam logic [CELL_W-1:0] WINDOW_SPAN = 10'h00F;
  localparam int WSR_BITS = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_MIN_NS = 10;
  localparam int RESET_CYCLES_RAW = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYCLES = (RESET_CYCLES_RAW < 1) ? 1 : RESET_CYCLES_RAW;
  localparam int LOCK_TIME_NS = 10000;
  localparam int LOCK_CYCLES = LOCK_TIME_NS / CLK_PERIOD_NS;
  localparam int LOCK_W = 9;
  localparam logic [LOCK_W-1:0] LOCK_MAX = LOCK_W'(LOCK_CYCLES);
  localparam logic [LOCK_W-1:0] LOCK_ON = LOCK_W'(LOCK_CYCLES / 4);
  localparam logic [LOCK_W-1:0] LOCK_OFF = LOCK_W'(LOCK_CYCLES / 2);
  localparam logic [LOCK_W-1:0] LOCK_ZERO = 9'h000;
  localparam logic [LOCK_W-1:0] LOCK_STEP = 9'h001;
  localparam logic [3:0] RESET_CNT_ZERO = 4'h0;

  // ----------------------------------------------------------------
  // Pin positions inside the synchronised control bus
  // ----------------------------------------------------------------
  localparam int CTRL_PINS = 4;

  // Filtered control levels in the system domain
  typedef struct packed {
    logic ref_level;
    logic continuous;
    logic write_gate;
    logic run_enable;
  } swsc_ctrl_type;

  // Position and state of the active write window
  typedef struct packed {
    logic active;
    logic running;
    logic [CELL_W-1:0] head;
    logic [CELL_W-1:0] tail;
  } swsc_window_type;

endpackage : swsc_pkg

// [swsc_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module swsc_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Raw pins and filtered levels
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] levels_out
);

  // ----------------------------------------------------------------
  // Per-bit chain
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1_reg;
      logic stage2_reg;
      logic stage3_reg;

      // Stage one is read by stage two only
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
          stage3_reg <= 1'b0;
        end else begin
          stage1_reg <= pins_in[i];
          stage2_reg <= stage1_reg;
          stage3_reg <= stage2_reg;
        end
      end

      // Level changes once stages two and three agree
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          levels_out[i] <= 1'b0;
        end else if (stage2_reg == stage3_reg) begin
          levels_out[i] <= stage3_reg;
        end
      end
    end
  endgenerate

endmodule : swsc_pin_sync

// [swsc_ctrl_model.sv]
// Controller model driving the wave and shift pins
`timescale 1ns/1ns
module swsc_ctrl_model (
  // System clock
  input wire logic clk,
  // Wave pins
  output logic wave_run_enable,
  output logic sample_write_gate,
  output logic wave_continuous_select,
  // Shift pins
  output logic shift_clock_in,
  output logic shift_serial_in,
  output logic chain_shift_in,
  output logic read_shift_load
);
  // Quiet levels from time zero
  initial begin
    wave_run_enable = 1'h0;
    sample_write_gate = 1'h0;
    wave_continuous_select = 1'h1;
    shift_clock_in = 1'h0;
    shift_serial_in = 1'h0;
    chain_shift_in = 1'h0;
    read_shift_load = 1'h0;
  end

  // Mode settles before the launch edge
  task automatic start_wave(input logic cont, input logic gate);
    @(posedge clk) #2 wave_continuous_select = cont;
    repeat (8) @(posedge clk);
    #2 sample_write_gate = gate;
    wave_run_enable = 1'h1;
  endtask : start_wave

  // Gate falls a full cycle before enable
  task automatic stop_wave();
    @(posedge clk) #2 sample_write_gate = 1'h0;
    @(posedge clk) #2 wave_run_enable = 1'h0;
  endtask : stop_wave

  // Gate alone, for readout phases
  task automatic set_gate(input logic gate);
    @(posedge clk) #2 sample_write_gate = gate;
  endtask : set_gate

  // One link period; data moves only while the clock is low
  task automatic shift_one(input logic ld, input logic ser, input logic chn);
    read_shift_load = ld;
    shift_serial_in = ser;
    chain_shift_in = chn;
    #7 shift_clock_in = 1'h1;
    #8 shift_clock_in = 1'h0;
  endtask : shift_one
endmodule : swsc_ctrl_model

// [swsc_monitor.sv]
// Checker of wave window, tap and shift outputs
`timescale 1ns/1ns
module swsc_monitor (
  // Clocks and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic shift_clock_in,
  // Wave pins
  input wire logic wave_run_enable,
  input wire logic sample_write_gate,
  input wire logic wave_continuous_select,
  // Outputs under check
  input wire logic chain_shift_out,
  input wire logic muxed_shift_out,
  input wire logic wave_tap_out,
  input wire swsc_pkg::swsc_window_type write_window
);
  // Window field shorthands
  wire run = write_window.running;
  wire act = write_window.active;
  wire [9:0] head = write_window.head;

  // Launch needs a settled low then a held high
  sequence run_low_s;
    !wave_run_enable [*6];
  endsequence
  sequence run_high_s;
    wave_run_enable [*8];
  endsequence

  span_fixed_a: assert property (@(posedge clk) disable iff (!reset_n)
    run |-> write_window.tail == head - swsc_pkg::WINDOW_SPAN) else $error("span wrong");
  head_step_a: assert property (@(posedge clk) disable iff (!reset_n)
    run && $past(run) |-> head == $past(head) + 10'h001) else $error("head skipped");
  write_in_run_a: assert property (@(posedge clk) disable iff (!reset_n)
    act |-> run) else $error("write without wave");
  gate_low_a: assert property (@(posedge clk) disable iff (!reset_n)
    !sample_write_gate [*8] |-> !act) else $error("write without gate");
  tap_at_cell_a: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(wave_tap_out) |-> head == swsc_pkg::CELL_TAP || $past(head) == swsc_pkg::CELL_TAP
    || $past(head, 2) == swsc_pkg::CELL_TAP) else $error("tap off cell");
  halt_low_a: assert property (@(posedge clk) disable iff (!reset_n)
    !wave_run_enable [*8] |-> !run) else $error("wave not halted");
  launch_run_a: assert property (@(posedge clk) disable iff (!reset_n)
    run_low_s ##1 run_high_s |-> run) else $error("wave not launched");
  single_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
    !wave_continuous_select [*8] ##0 (run && head == swsc_pkg::CELL_LAST)
    |=> ##[0:1] !run) else $error("single pass kept on");
  shift_mux_a: assert property (@(posedge shift_clock_in) disable iff (!reset_n)
    chain_shift_out == muxed_shift_out) else $error("shift outputs differ");
endmodule : swsc_monitor

bind swsc_top swsc_monitor u_mon (.clk, .reset_n, .shift_clock_in, .wave_run_enable,
  .sample_write_gate, .wave_continuous_select, .chain_shift_out, .muxed_shift_out,
  .wave_tap_out, .write_window);

// [swsc_top_test.sv]
// Self-checking bench of the sampler wave and shift control
`timescale 1ns/1ns
module swsc_top_test;
  // ----
  // Wiring
  // ----
  typedef struct {logic cont; logic gate; int hold; logic run; logic act; logic tap;} swsc_row_type;
  logic clk, reset_n, ref_clock_in, ref_invert;
  logic wave_run_enable, sample_write_gate, wave_continuous_select;
  logic shift_clock_in, shift_serial_in, chain_shift_in, read_shift_load;
  logic chain_shift_out, muxed_shift_out, wave_tap_out, lock_indicator;
  logic [23:0] pat;
  swsc_pkg::swsc_window_type write_window;
  int mismatches, checks, ones;
  swsc_row_type rows [5] = '{'{1'h1, 1'h1, 20, 1'h1, 1'h1, 1'h0},
    '{1'h1, 1'h0, 20, 1'h1, 1'h0, 1'h0}, '{1'h0, 1'h1, 1100, 1'h0, 1'h0, 1'h1},
    '{1'h1, 1'h0, 1100, 1'h1, 1'h0, 1'h0}, '{1'h1, 1'h1, 1300, 1'h1, 1'h1, 1'h1}};

  swsc_ctrl_model u_ctrl (.clk, .wave_run_enable, .sample_write_gate, .wave_continuous_select,
    .shift_clock_in, .shift_serial_in, .chain_shift_in, .read_shift_load);
  swsc_top u_dut (.clk, .reset_n, .wave_run_enable, .sample_write_gate,
    .wave_continuous_select, .ref_clock_in, .shift_clock_in, .shift_serial_in,
    .chain_shift_in, .read_shift_load, .chain_shift_out, .muxed_shift_out,
    .wave_tap_out, .lock_indicator, .write_window);

  // System clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // Reference follows the tap, or its inverse
  always @(posedge clk) begin
    #2 ref_clock_in = wave_tap_out ^ ref_invert;
  end

  // ----
  // Helpers
  // ----
  task automatic check_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask : check_bit

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // Bounded wait for the wave state
  task automatic wait_run(input logic level);
    int n;
    n = 0;
    while (write_window.running !== level && n < 20) begin
      @(posedge clk) #2;
      n++;
    end
    check_bit(write_window.running, level, "running");
    if (write_window.running !== level) close_out();
  endtask : wait_run

  // ----
  // Main sequence
  // ----
  initial begin
    reset_n = 1'h0;
    ref_invert = 1'h0;
    pat = 24'hC35A96;
    repeat (12) @(posedge clk);
    check_bit(lock_indicator, 1'h0, "lock in reset");
    #2 reset_n = 1'h1;
    // Table of acquisitions
    foreach (rows[i]) begin
      u_ctrl.start_wave(rows[i].cont, rows[i].gate);
      wait_run(1'h1);
      repeat (rows[i].hold) @(posedge clk);
      #2;
      check_bit(write_window.running, rows[i].run, "run");
      check_bit(write_window.active, rows[i].act, "active");
      check_bit(wave_tap_out, rows[i].tap, "tap");
      u_ctrl.stop_wave();
      wait_run(1'h0);
      $display("row %0d done", i);
    end
    // Write register passes chain data with the gate high
    u_ctrl.set_gate(1'h1);
    for (int k = 0; k < 24; k++) begin
      u_ctrl.shift_one(1'h0, 1'h0, pat[23-k]);
      if (k >= 14) check_bit(chain_shift_out, pat[30-k], "chain");
    end
    $display("write chain done");
    // Read register: one token after a load, then serial fill
    u_ctrl.set_gate(1'h0);
    repeat (8) u_ctrl.shift_one(1'h0, 1'h0, 1'h0);
    ones = 0;
    for (int k = 0; k < 1024; k++) begin
      u_ctrl.shift_one(k == 0, 1'h0, 1'h0);
      if (muxed_shift_out !== 1'h0) ones++;
    end
    check_bit(ones == 1, 1'h1, "token count");
    repeat (1024) u_ctrl.shift_one(1'h0, 1'h1, 1'h0);
    check_bit(muxed_shift_out, 1'h1, "serial fill");
    check_bit(chain_shift_out, 1'h1, "chain read");
    $display("read chain done");
    // Reset in mid-run clears the wave
    u_ctrl.start_wave(1'h1, 1'h1);
    wait_run(1'h1);
    @(posedge clk) #2 reset_n = 1'h0;
    #1 check_bit(write_window.running, 1'h0, "reset run");
    u_ctrl.stop_wave();
    @(posedge clk) #2 reset_n = 1'h1;
    check_bit(lock_indicator, 1'h0, "lock after reset");
    repeat (10) @(posedge clk);
    #2 check_bit(write_window.running, 1'h0, "no relaunch");
    $display("mid reset done");
    // Lock follows the tap to reference relation
    repeat (300) @(posedge clk);
    #2 check_bit(lock_indicator, 1'h1, "locked");
    ref_invert = 1'h1;
    repeat (300) @(posedge clk);
    #2 check_bit(lock_indicator, 1'h0, "unlocked");
    $display("lock done");
    close_out();
  end
endmodule : swsc_top_test
